// file: rtl/fmpr_cfg.svh
`ifndef FMPR_CFG_SVH
`define FMPR_CFG_SVH
// data rate codes
`define FMPR_RATE_500 2'h0
`define FMPR_RATE_300 2'h1
`define FMPR_RATE_250 2'h2
`define FMPR_RATE_1M 2'h3
// density select field codes
`define FMPR_DS_LOW 2'h0
`define FMPR_DS_HIGH 2'h1
`define FMPR_DS_DEFAULT 2'h3
// reset values of mode options
`define FMPR_SETTLE_RST 4'h8
`define FMPR_DS_RST 2'h3
// gap2 byte counts
`define FMPR_GAP2_FMT_STD 6'h16
`define FMPR_GAP2_FMT_PERP1M 6'h29
`define FMPR_GAP2_WR_CONV 6'h00
`define FMPR_GAP2_WR_PERP 6'h13
`define FMPR_GAP2_WR_PERP1M 6'h26
// sector size base length
`define FMPR_SECTOR_BASE 15'h0080
// settle step times in microseconds, per unit of n
`define FMPR_STEP_US_250 8000
`define FMPR_STEP_US_300 6666
`define FMPR_STEP_US_500 4000
`define FMPR_STEP_US_1M 2000
`define FMPR_CLK_MHZ 125
// scan wildcard byte
`define FMPR_WILD_BYTE 8'hff
`endif

// file: rtl/fmpr_pkg.sv
package fmpr_pkg;
  // read data opening sequence states
  typedef enum logic [5:0] {
    FMPR_IDLE = 6'h01,
    FMPR_MOTOR = 6'h02,
    FMPR_SEEK = 6'h04,
    FMPR_SENSE = 6'h08,
    FMPR_SETTLE = 6'h10,
    FMPR_SEARCH = 6'h20
  } fmpr_state_t;
  // mode command options
  typedef struct packed {
    logic [1:0] density_sel;
    logic drive_buffer_type;
    logic scan_wildcard_off;
    logic [3:0] settle_n;
    logic read_gate_diag;
    logic pump_pulse_diag;
    logic implied_seek_cmd_en;
  } fmpr_mode_t;
  // perpendicular mode command byte
  typedef struct packed {
    logic config_overwrite_en;
    logic [3:0] drive_perp_config;
    logic gap_select;
    logic write_gate_select;
  } fmpr_perp_t;
endpackage

// file: rtl/fmpr_core.sv
`include "fmpr_cfg.svh"
// ****************************************************************
// ****************************************************************
module fmpr_core
  import fmpr_pkg::*;
#(
  parameter logic [7:0] VERSION_ID = 8'h50 // arbitrary family and revision value
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic soft_reset,
  input wire fmpr_mode_t mode_cfg,
  input wire logic mode_load,
  input wire fmpr_perp_t perp_cmd,
  input wire logic perp_load,
  input wire logic [1:0] data_rate,
  input wire logic drive_type_in,
  input wire logic [1:0] drive_sel,
  input wire logic disk_change_in,
  input wire logic pump_up,
  input wire logic pump_down,
  input wire logic mfm_normal,
  input wire logic [7:0] scan_host_byte,
  input wire logic [7:0] scan_disk_byte,
  input wire logic version_query_cmd,
  input wire logic read_start,
  input wire logic read_cmd_seek_bit,
  input wire logic config_implied_seek,
  input wire logic [2:0] size_code,
  input wire logic motor_time_done,
  input wire logic seek_done,
  input wire logic sense_done,
  input wire logic data_mark_deleted,
  output logic density_select_out,
  output logic drive_buffer_type,
  output logic [7:0] scan_equal_mask,
  output logic read_gate_ext,
  output logic disk_change_out,
  output logic encoding_pin,
  output logic [7:0] result_byte,
  output logic result_valid,
  output logic [3:0] drive_is_perp,
  output logic precomp_zero,
  output logic [5:0] gap2_format,
  output logic [5:0] gap2_write,
  output logic motor_wait,
  output logic seek_req,
  output logic sense_req,
  output logic search_start,
  output logic transfer_ok,
  output logic [14:0] sector_len
);
  // ************************************************************
  // settle step counts in cycles
  // ************************************************************
  localparam int C250 = `FMPR_STEP_US_250 * `FMPR_CLK_MHZ;
  localparam int C300 = `FMPR_STEP_US_300 * `FMPR_CLK_MHZ;
  localparam int C500 = `FMPR_STEP_US_500 * `FMPR_CLK_MHZ;
  localparam int C1M = `FMPR_STEP_US_1M * `FMPR_CLK_MHZ;

  // ************************************************************
  // option registers
  // ************************************************************
  fmpr_mode_t mode_reg, mode_next; // mode command options
  logic [3:0] dc_reg, dc_next; // per-drive configuration
  logic gap_reg, gap_next; // gap select
  logic wg_reg, wg_next; // write gate select
  logic [7:0] res_reg, res_next; // version answer byte
  logic rv_reg, rv_next; // version answer valid

  // next values of options
  always_comb begin
    mode_next = mode_reg;
    dc_next = dc_reg;
    gap_next = gap_reg;
    wg_next = wg_reg;
    res_next = res_reg;
    rv_next = 1'b0;
    if (mode_load) begin
      mode_next = mode_cfg;
    end
    if (soft_reset) begin
      gap_next = 1'b0;
      wg_next = 1'b0;
    end else if (perp_load) begin
      gap_next = perp_cmd.gap_select;
      wg_next = perp_cmd.write_gate_select;
      if (perp_cmd.config_overwrite_en) begin
        dc_next = perp_cmd.drive_perp_config;
      end
    end
    if (version_query_cmd) begin
      res_next = VERSION_ID;
      rv_next = 1'b1;
    end
  end

  // hard reset clears every perpendicular bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= '{density_sel: `FMPR_DS_RST, settle_n: `FMPR_SETTLE_RST, default: 1'b0};
      dc_reg <= 4'h0;
      gap_reg <= 1'b0;
      wg_reg <= 1'b0;
      res_reg <= 8'h00;
      rv_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      dc_reg <= dc_next;
      gap_reg <= gap_next;
      wg_reg <= wg_next;
      res_reg <= res_next;
      rv_reg <= rv_next;
    end
  end
  assign result_byte = res_reg;
  assign result_valid = rv_reg;
  // ************************************************************
  // drive pins and diagnostics
  // ************************************************************
  logic fast_rate; // 500 kb/s or 1 mb/s
  assign fast_rate = (data_rate == `FMPR_RATE_500) || (data_rate == `FMPR_RATE_1M);
  // density pin; undefined code behaves as default
  always_comb begin
    case (mode_reg.density_sel)
      `FMPR_DS_LOW: density_select_out = 1'b0;
      `FMPR_DS_HIGH: density_select_out = 1'b1;
      default: density_select_out = fast_rate ~^ drive_type_in;
    endcase
  end
  assign drive_buffer_type = mode_reg.drive_buffer_type;
  assign read_gate_ext = mode_reg.read_gate_diag & disk_change_in;
  assign disk_change_out = mode_reg.read_gate_diag ? 1'b0 : disk_change_in;
  // pump pulse is active low
  assign encoding_pin = mode_reg.pump_pulse_diag ? ~(pump_up | pump_down) : mfm_normal;
  // scan compare with ff wildcard per bit of equality
  always_comb begin
    if (!mode_reg.scan_wildcard_off &&
        (scan_host_byte == `FMPR_WILD_BYTE || scan_disk_byte == `FMPR_WILD_BYTE)) begin
      scan_equal_mask = 8'hff;
    end else begin
      scan_equal_mask = ~(scan_host_byte ^ scan_disk_byte);
    end
  end

  // ************************************************************
  // perpendicular selection and gap2
  // ************************************************************
  logic sel_perp; // selected drive perpendicular
  logic is_1m;
  assign is_1m = data_rate == `FMPR_RATE_1M;
  // gap/wg override the per-drive bits in drive_is_perp when not both zero; precomp_zero still uses dc_reg
  assign drive_is_perp = (gap_reg | wg_reg) ? {4{wg_reg}} : dc_reg;
  assign sel_perp = drive_is_perp[drive_sel];
  assign precomp_zero = dc_reg[drive_sel];
  always_comb begin
    gap2_format = `FMPR_GAP2_FMT_STD;
    gap2_write = `FMPR_GAP2_WR_CONV;
    if (gap_reg | wg_reg) begin
      // table by gap and wg
      if (wg_reg) begin
        gap2_format = gap_reg ? `FMPR_GAP2_FMT_PERP1M : `FMPR_GAP2_FMT_STD;
        gap2_write = gap_reg ? `FMPR_GAP2_WR_PERP1M : `FMPR_GAP2_WR_PERP;
      end
    end else if (sel_perp) begin
      gap2_format = is_1m ? `FMPR_GAP2_FMT_PERP1M : `FMPR_GAP2_FMT_STD;
      gap2_write = is_1m ? `FMPR_GAP2_WR_PERP1M : `FMPR_GAP2_WR_PERP;
    end
  end

  // ************************************************************
  // read data opening sequence
  // ************************************************************
  fmpr_state_t st_reg, st_next;
  logic [19:0] step_reg, step_next; // cycles within one settle unit
  logic [3:0] units_reg, units_next; // settle units left
  logic seek_en_reg, seek_en_next; // implied seek latched at start
  logic [19:0] step_max; // rate dependent step length
  always_comb begin
    case (data_rate)
      `FMPR_RATE_250: step_max = 20'(C250 - 1);
      `FMPR_RATE_300: step_max = 20'(C300 - 1);
      `FMPR_RATE_1M: step_max = 20'(C1M - 1);
      default: step_max = 20'(C500 - 1);
    endcase
  end

  // sequence next state
  always_comb begin
    st_next = st_reg;
    step_next = step_reg;
    units_next = units_reg;
    seek_en_next = seek_en_reg;
    case (st_reg)
      FMPR_IDLE: begin
        if (read_start) begin
          seek_en_next = (mode_reg.implied_seek_cmd_en & read_cmd_seek_bit) | config_implied_seek;
          st_next = FMPR_MOTOR;
        end
      end
      FMPR_MOTOR: begin
        if (motor_time_done) begin
          st_next = seek_en_reg ? FMPR_SEEK : FMPR_SEARCH;
        end
      end
      FMPR_SEEK: begin
        if (seek_done) begin
          st_next = FMPR_SENSE;
        end
      end
      FMPR_SENSE: begin
        if (sense_done) begin
          units_next = mode_reg.settle_n;
          step_next = 20'h0;
          st_next = (mode_reg.settle_n == 4'h0) ? FMPR_SEARCH : FMPR_SETTLE;
        end
      end
      FMPR_SETTLE: begin
        if (step_reg >= step_max) begin
          step_next = 20'h0;
          units_next = units_reg - 4'h1;
          if (units_reg == 4'h1) begin
            st_next = FMPR_SEARCH;
          end
        end else begin
          step_next = step_reg + 20'h1;
        end
      end
      FMPR_SEARCH: st_next = FMPR_IDLE;
      default: st_next = FMPR_IDLE;
    endcase
    if (soft_reset) begin
      st_next = FMPR_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= FMPR_IDLE;
      step_reg <= 20'h0;
      units_reg <= 4'h0;
      seek_en_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      step_reg <= step_next;
      units_reg <= units_next;
      seek_en_reg <= seek_en_next;
    end
  end

  // the motor itself is the host's job; we only wait for motor_time_done
  assign motor_wait = st_reg == FMPR_MOTOR;
  assign seek_req = st_reg == FMPR_SEEK;
  assign sense_req = st_reg == FMPR_SENSE;
  assign search_start = st_reg == FMPR_SEARCH;
  assign transfer_ok = ~data_mark_deleted;
  assign sector_len = `FMPR_SECTOR_BASE << size_code;
  // ************************************************************
  // checks
  // ************************************************************
  property p_soft_keep;
    @(posedge clk) disable iff (!rst_n)
      soft_reset |=> (!gap_reg && !wg_reg && dc_reg == $past(dc_reg));
  endproperty
  a_soft_keep: assert property (p_soft_keep) else $error("soft reset gap bits");
  property p_ow_off;
    @(posedge clk) disable iff (!rst_n)
      (perp_load && !perp_cmd.config_overwrite_en) |=> $stable(dc_reg);
  endproperty
  a_ow_off: assert property (p_ow_off) else $error("drive config changed");
  property p_ow_on;
    @(posedge clk) disable iff (!rst_n)
      (perp_load && perp_cmd.config_overwrite_en && !soft_reset)
        |=> dc_reg == $past(perp_cmd.drive_perp_config);
  endproperty
  a_ow_on: assert property (p_ow_on) else $error("drive config not loaded");
  property p_dens;
    @(posedge clk) disable iff (!rst_n)
      mode_reg.density_sel == `FMPR_DS_DEFAULT |-> density_select_out == (fast_rate == drive_type_in);
  endproperty
  a_dens: assert property (p_dens) else $error("density default wrong");
  property p_motor_first;
    @(posedge clk) disable iff (!rst_n)
      (st_reg == FMPR_IDLE && read_start && !soft_reset) |=> motor_wait;
  endproperty
  a_motor_first: assert property (p_motor_first) else $error("no motor wait");

  property p_seek_order;
    @(posedge clk) disable iff (!rst_n)
      (seek_req && seek_done && !soft_reset) |=> sense_req;
  endproperty
  a_seek_order: assert property (p_seek_order) else $error("sense not after seek");

  property p_zero_settle;
    @(posedge clk) disable iff (!rst_n)
      (sense_req && sense_done && mode_reg.settle_n == 4'h0 && !soft_reset) |=> search_start;
  endproperty
  a_zero_settle: assert property (p_zero_settle) else $error("zero settle delayed");

  property p_gap_1m;
    @(posedge clk) disable iff (!rst_n)
      (gap_reg && wg_reg) |-> (gap2_format == `FMPR_GAP2_FMT_PERP1M && gap2_write == `FMPR_GAP2_WR_PERP1M);
  endproperty
  a_gap_1m: assert property (p_gap_1m) else $error("gap2 1m wrong");

  property p_wild;
    @(posedge clk) disable iff (!rst_n)
      (!mode_reg.scan_wildcard_off && scan_host_byte == `FMPR_WILD_BYTE) |-> scan_equal_mask == 8'hff;
  endproperty
  a_wild: assert property (p_wild) else $error("wildcard missed");
endmodule

// file: dv/fmpr_drive_model.sv
// ****************************************
// drive side: answers motor, seek, sense
// ****************************************
module fmpr_drive_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] lat,
  input wire logic motor_wait,
  input wire logic seek_req,
  input wire logic sense_req,
  output logic motor_time_done,
  output logic seek_done,
  output logic sense_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_reg; // cycles the open request has waited
  // one-cycle answer after lat cycles; lat set per test, so prompt or slow
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 4'h0;
      motor_time_done <= 1'b0;
      seek_done <= 1'b0;
      sense_done <= 1'b0;
    end else begin
      motor_time_done <= 1'b0;
      seek_done <= 1'b0;
      sense_done <= 1'b0;
      // restart after a pulse so one request never gets two answers
      if (!(motor_wait | seek_req | sense_req) | motor_time_done | seek_done | sense_done) begin
        cnt_reg <= 4'h0;
      end else if (cnt_reg == lat) begin
        motor_time_done <= motor_wait;
        seek_done <= seek_req;
        sense_done <= sense_req;
        cnt_reg <= 4'h0;
      end else begin
        cnt_reg <= cnt_reg + 4'h1;
      end
    end
  end
endmodule

// file: dv/fmpr_core_bench.sv
`define CHK(g, e, m) begin check_count++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD %0t %s", $time, m); end end
module fmpr_core_bench;
  import fmpr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // stimulus and design hookup
  // ****************************************
  logic clk = 0, rst_n = 0, soft_reset = 0, mode_load = 0, perp_load = 0;
  fmpr_mode_t mode_cfg = '{2'h3, 1'h0, 1'h0, 4'h8, 1'h0, 1'h0, 1'h0};
  fmpr_perp_t perp_cmd = '0;
  logic [1:0] data_rate = 2'h0, drive_sel = 2'h0;
  logic drive_type_in = 1, disk_change_in = 0, pump_up = 0, pump_down = 0, mfm_normal = 1;
  logic [7:0] scan_host_byte = 8'h00, scan_disk_byte = 8'h00;
  logic version_query_cmd = 0, read_start = 0, read_cmd_seek_bit = 0, config_implied_seek = 0;
  logic [2:0] size_code = 3'h0;
  logic data_mark_deleted = 0;
  logic [3:0] lat = 4'h2; // drive answer delay
  logic motor_time_done, seek_done, sense_done, density_select_out, drive_buffer_type;
  logic read_gate_ext, disk_change_out, encoding_pin, result_valid, precomp_zero;
  logic motor_wait, seek_req, sense_req, search_start, transfer_ok;
  logic [7:0] scan_equal_mask, result_byte;
  logic [3:0] drive_is_perp;
  logic [5:0] gap2_format, gap2_write;
  logic [14:0] sector_len;
  int num_errors = 0, check_count = 0;
  always #4 clk = ~clk; // 125 MHz
  // version value is arbitrary
  fmpr_core #(.VERSION_ID(8'h5a)) fmpr_core_i (
    .clk(clk), .rst_n(rst_n), .soft_reset(soft_reset), .mode_cfg(mode_cfg),
    .mode_load(mode_load), .perp_cmd(perp_cmd), .perp_load(perp_load), .data_rate(data_rate),
    .drive_type_in(drive_type_in), .drive_sel(drive_sel), .disk_change_in(disk_change_in),
    .pump_up(pump_up), .pump_down(pump_down), .mfm_normal(mfm_normal),
    .scan_host_byte(scan_host_byte), .scan_disk_byte(scan_disk_byte),
    .version_query_cmd(version_query_cmd), .read_start(read_start),
    .read_cmd_seek_bit(read_cmd_seek_bit), .config_implied_seek(config_implied_seek),
    .size_code(size_code), .motor_time_done(motor_time_done), .seek_done(seek_done),
    .sense_done(sense_done), .data_mark_deleted(data_mark_deleted),
    .density_select_out(density_select_out), .drive_buffer_type(drive_buffer_type),
    .scan_equal_mask(scan_equal_mask), .read_gate_ext(read_gate_ext),
    .disk_change_out(disk_change_out), .encoding_pin(encoding_pin), .result_byte(result_byte),
    .result_valid(result_valid), .drive_is_perp(drive_is_perp), .precomp_zero(precomp_zero),
    .gap2_format(gap2_format), .gap2_write(gap2_write), .motor_wait(motor_wait),
    .seek_req(seek_req), .sense_req(sense_req), .search_start(search_start),
    .transfer_ok(transfer_ok), .sector_len(sector_len));
  fmpr_drive_model fmpr_drive_model_i (
    .clk(clk), .rst_n(rst_n), .lat(lat), .motor_wait(motor_wait), .seek_req(seek_req),
    .sense_req(sense_req), .motor_time_done(motor_time_done), .seek_done(seek_done),
    .sense_done(sense_done));
  // ****************************************
  // access tasks
  // ****************************************
  // inputs change a fixed 1 ns after the rising edge
  task tk(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask
  task mode(input fmpr_mode_t m);
    mode_cfg = m;
    mode_load = 1;
    tk(1);
    mode_load = 0;
    tk(1);
  endtask
  task perp(input fmpr_perp_t p);
    perp_cmd = p;
    perp_load = 1;
    tk(1);
    perp_load = 0;
    tk(1);
  endtask
  task g2(input logic [1:0] r, input logic [1:0] d, input logic [5:0] f, input logic [5:0] w);
    data_rate = r;
    drive_sel = d;
    tk(2);
    `CHK(gap2_format, f, "gap2 format")
    `CHK(gap2_write, w, "gap2 write")
  endtask
  // read opening sequence; bounded wait for the search pulse
  task rd(input logic cb, input logic cf, input logic ex);
    logic sk;
    read_cmd_seek_bit = cb;
    config_implied_seek = cf;
    read_start = 1;
    tk(1);
    read_start = 0;
    sk = 0;
    `CHK(motor_wait, 1'b1, "motor wait")
    for (int i = 0; i < 200 && search_start !== 1'b1; i++) begin
      sk |= seek_req;
      tk(1);
    end
    `CHK(search_start, 1'b1, "search start")
    `CHK(sk, ex, "implied seek")
    tk(1);
  endtask
  task tend(input string s);
    $display("test %s done, errors %0d", s, num_errors);
  endtask
  task test_done();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ****************************************
  // tests
  // ****************************************
  // watchdog well above the expected few hundred cycles
  initial begin
    #400000;
    num_errors++;
    test_done();
  end
  initial begin
    fmpr_mode_t m;
    logic seen, exp_d;
    tk(3);
    rst_n = 1;
    tk(1);
    `CHK(drive_buffer_type, 1'b0, "buffer reset")
    `CHK(drive_is_perp, 4'h0, "perp reset")
    m = mode_cfg;
    // density: forced low, forced high, default per rate and type
    // code 10 is undefined and is expected to act as the default
    for (int c = 0; c < 4; c++) begin
      m.density_sel = (c == 3) ? 2'h2 : ((c == 2) ? 2'h3 : c[1:0]);
      mode(m);
      for (int r = 0; r < 8; r++) begin
        data_rate = r[1:0];
        drive_type_in = r[2];
        tk(2);
        exp_d = (c >= 2) ? ((r[1:0] == 0 || r[1:0] == 3) ^ !r[2]) : c[0];
        `CHK(density_select_out, exp_d, "density")
      end
    end
    tend("density");
    m.drive_buffer_type = 1;
    m.read_gate_diag = 1;
    m.pump_pulse_diag = 1;
    mode(m);
    disk_change_in = 1;
    pump_up = 1;
    scan_host_byte = 8'hff;
    scan_disk_byte = 8'h12;
    tk(2);
    `CHK(drive_buffer_type, 1'b1, "open drain")
    `CHK(read_gate_ext, 1'b1, "read gate")
    `CHK(encoding_pin, 1'b0, "pump pulse")
    `CHK(scan_equal_mask, 8'hff, "wildcard")
    `CHK(disk_change_out, 1'b0, "disk change masked")
    scan_host_byte = 8'h12;
    scan_disk_byte = 8'hff;
    tk(1);
    `CHK(scan_equal_mask, 8'hff, "disk wildcard")
    m.scan_wildcard_off = 1;
    m.read_gate_diag = 0;
    m.pump_pulse_diag = 0;
    mode(m);
    tk(1);
    `CHK(scan_equal_mask == 8'hff, 1'b0, "no wildcard")
    `CHK(disk_change_out, 1'b1, "disk change")
    `CHK(encoding_pin, 1'b1, "encoding normal")
    tend("mode options");
    version_query_cmd = 1;
    tk(1);
    version_query_cmd = 0;
    `CHK(result_valid, 1'b1, "version valid")
    `CHK(result_byte, 8'h5a, "version byte")
    tk(1);
    `CHK(result_valid, 1'b0, "version pulse")
    tend("version");
    perp('{1'h1, 4'ha, 1'h0, 1'h0});
    perp('{1'h0, 4'h5, 1'h0, 1'h0});
    `CHK(drive_is_perp, 4'ha, "overwrite off")
    g2(2'h3, 2'h1, 6'h29, 6'h26);
    `CHK(precomp_zero, 1'b1, "precomp")
    g2(2'h0, 2'h1, 6'h16, 6'h13);
    g2(2'h3, 2'h0, 6'h16, 6'h00);
    `CHK(precomp_zero, 1'b0, "precomp conv")
    perp('{1'h0, 4'h0, 1'h1, 1'h1});
    g2(2'h3, 2'h0, 6'h29, 6'h26);
    perp('{1'h0, 4'h0, 1'h1, 1'h0});
    g2(2'h3, 2'h1, 6'h16, 6'h00);
    perp('{1'h0, 4'h0, 1'h0, 1'h1});
    g2(2'h0, 2'h0, 6'h16, 6'h13);
    soft_reset = 1;
    tk(1);
    soft_reset = 0;
    g2(2'h3, 2'h0, 6'h16, 6'h00);
    `CHK(drive_is_perp, 4'ha, "soft keeps")
    tend("perpendicular");
    for (int s = 0; s < 8; s++) begin
      size_code = s[2:0];
      tk(2);
      `CHK(sector_len, 15'h0080 << s, "sector size")
    end
    tend("sector size");
    m.settle_n = 0;
    mode(m);
    rd(1, 0, 0);
    m.implied_seek_cmd_en = 1;
    mode(m);
    rd(1, 0, 1);
    lat = 4'h9;
    rd(0, 1, 1);
    rd(0, 0, 0);
    // nonzero settle holds the search back until soft reset aborts it
    m.settle_n = 4'h1;
    mode(m);
    read_cmd_seek_bit = 1;
    read_start = 1;
    tk(1);
    read_start = 0;
    seen = 0;
    for (int i = 0; i < 80; i++) begin
      seen |= search_start;
      tk(1);
    end
    `CHK(seen, 1'b0, "settle wait")
    `CHK({motor_wait, seek_req, sense_req}, 3'h0, "settling")
    soft_reset = 1;
    tk(1);
    soft_reset = 0;
    rd(0, 0, 0);
    `CHK(transfer_ok, 1'b1, "normal mark")
    data_mark_deleted = 1;
    tk(2);
    `CHK(transfer_ok, 1'b0, "deleted mark")
    tend("read");
    rst_n = 0;
    tk(1);
    rst_n = 1;
    tk(1);
    `CHK(drive_is_perp, 4'h0, "hard reset")
    `CHK(drive_buffer_type, 1'b0, "hard reset mode")
    tend("hard reset");
    test_done();
  end
endmodule
